// [mtu_pkg.sv]
// Purpose: shared constants and carriers for the two-channel match timer unit
// Assumes: APB word map, one aligned 32-bit word per register
// Notes: word index is paddr[7:2]
package mtu_pkg;
  localparam int NCH = 2;
  localparam int PRESC_W = 9;
  localparam logic [5:0] IDX_RUN = 6'h00;
  localparam logic [5:0] IDX_CH0 = 6'h01;
  localparam logic [5:0] IDX_STRIDE = 6'h03;
  localparam logic [5:0] SUB_CSR = 6'h00;
  localparam logic [5:0] SUB_CNT = 6'h01;
  localparam logic [5:0] SUB_PER = 6'h02;
  localparam int CSR_FLAG_BIT = 7;
  localparam int CSR_IE_BIT = 6;
  localparam int CSR_CKS_LO = 0;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] PER_RST = 16'hFFFF;
  localparam logic [1:0] CKS_RST = 2'h0;
  localparam logic [PRESC_W-1:0] DIV8_MASK = 9'h007;
  localparam logic [PRESC_W-1:0] DIV32_MASK = 9'h01F;
  localparam logic [PRESC_W-1:0] DIV128_MASK = 9'h07F;
  localparam logic [PRESC_W-1:0] DIV512_MASK = 9'h1FF;

  typedef struct packed {
    logic flag;
    logic ie;
    logic [1:0] cks;
    logic [15:0] cnt;
    logic [15:0] per;
  } mtu_chan_t;

  typedef struct packed {
    logic wr_csr;
    logic wr_cnt;
    logic wr_per;
    logic rd_csr;
    logic [1:0] strb;
    logic [15:0] wdata;
  } mtu_acc_t;
endpackage : mtu_pkg

// [mtu_channel.sv]
// Purpose: one match timer channel: counter, period, flag, enable, request
// Assumes: acc strobes are single-cycle APB commits from the top
// Notes: tick is already gated by the channel run bit
`timescale 1ns/1ps
`default_nettype none
module mtu_channel
  import mtu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic standby,
  input wire logic tick,
  input wire logic xfer_clr,
  input wire mtu_acc_t acc,
  output mtu_chan_t regs,
  output logic irq
);
  logic flag_r, flag_nxt, ie_r, ie_nxt, seen_r, irq_r;
  logic [1:0] cks_r;
  logic [15:0] cnt_r, cnt_nxt, per_r, wr_merge;

  wire match = tick & (cnt_r == per_r); // R03
  wire sw_clear = acc.wr_csr & acc.strb[0] & ~acc.wdata[CSR_FLAG_BIT] & seen_r; // R04
  assign wr_merge = {acc.strb[1] ? acc.wdata[15:8] : cnt_r[15:8],
                     acc.strb[0] ? acc.wdata[7:0] : cnt_r[7:0]}; // R08
  // Set wins over either clear; writing 1 never sets
  assign flag_nxt = match | (flag_r & ~sw_clear & ~xfer_clr); // R03 R04 R05 R12
  assign ie_nxt = (acc.wr_csr & acc.strb[0]) ? acc.wdata[CSR_IE_BIT] : ie_r;
  // Clear beats write, write beats increment
  assign cnt_nxt = match ? CNT_RST : // R06 R10
                   acc.wr_cnt ? wr_merge : // R07 R08
                   tick ? cnt_r + 16'h0001 : cnt_r; // R09

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 1'b0;
      ie_r <= 1'b0;
      cks_r <= CKS_RST;
      cnt_r <= CNT_RST;
      per_r <= PER_RST;
      seen_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (standby) begin
      flag_r <= 1'b0; // R11
      ie_r <= 1'b0;
      cks_r <= CKS_RST;
      cnt_r <= CNT_RST;
      per_r <= PER_RST;
      seen_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      ie_r <= ie_nxt;
      if (acc.wr_csr && acc.strb[0]) begin
        cks_r <= acc.wdata[CSR_CKS_LO +: 2];
      end
      cnt_r <= cnt_nxt;
      if (acc.wr_per) begin
        per_r <= wr_merge_per(per_r, acc);
      end
      // Read of a set flag arms the clear; any flag write disarms it
      seen_r <= acc.rd_csr ? flag_r : (acc.wr_csr ? 1'b0 : seen_r); // R04
      irq_r <= flag_nxt & ie_nxt; // R02
    end
  end

  function automatic logic [15:0] wr_merge_per(input logic [15:0] old, input mtu_acc_t a);
    wr_merge_per = {a.strb[1] ? a.wdata[15:8] : old[15:8], a.strb[0] ? a.wdata[7:0] : old[7:0]};
  endfunction : wr_merge_per

  assign regs = '{flag: flag_r, ie: ie_r, cks: cks_r, cnt: cnt_r, per: per_r};
  assign irq = irq_r;

  a_irq_both_set: assert property (@(posedge clk) disable iff (!rst_b)
    irq_r == (flag_r & ie_r)) else $error("request not equal to flag and enable"); // R02
  a_flag_rise_tick: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(flag_r) |-> $past(match)) else $error("flag rose without match tick"); // R03
  a_match_sets: assert property (@(posedge clk) disable iff (!rst_b)
    match && !standby |=> flag_r && cnt_r == CNT_RST) else $error("match did not set/clear"); // R10
  a_match_beats_wr: assert property (@(posedge clk) disable iff (!rst_b)
    match && acc.wr_cnt && !standby |=> cnt_r == CNT_RST) else $error("write beat match"); // R06
  a_word_wr_wins: assert property (@(posedge clk) disable iff (!rst_b)
    acc.wr_cnt && acc.strb == 2'b11 && !match && !standby |=> cnt_r == $past(acc.wdata))
    else $error("word write lost"); // R07
  a_byte_keeps: assert property (@(posedge clk) disable iff (!rst_b)
    acc.wr_cnt && acc.strb == 2'b01 && !match && !standby
    |=> cnt_r[15:8] == $past(cnt_r[15:8])) else $error("unwritten byte changed"); // R08
  a_xfer_clears: assert property (@(posedge clk) disable iff (!rst_b)
    xfer_clr && !match && !standby |=> !flag_r) else $error("transfer clear ignored"); // R05
  a_one_no_set: assert property (@(posedge clk) disable iff (!rst_b)
    !flag_r && !match |=> !flag_r) else $error("flag set without match"); // R12
  a_clear_needs_rd: assert property (@(posedge clk) disable iff (!rst_b)
    flag_r && !seen_r && !xfer_clr && !standby |=> flag_r) else $error("flag cleared unread"); // R04
endmodule : mtu_channel
`default_nettype wire

// [mtu_top.sv]
// Purpose: two-channel 16-bit compare match timer with APB register access
// Assumes: zero-wait APB slave, prescaler shared by both channels
// Notes: read data is captured in the setup cycle, one cycle before the access edge
// Function
// [R01] Each channel drives its own interrupt request output, one per vector.
// [R02] Request is high only while flag and enable are both one.
// [R03] Flag sets only when a tick arrives while counter equals the period.
// [R04] Flag clears by reading it as one, then writing zero to it.
// [R05] Transfer controller clear strobe also clears the flag.
// [R06] Match clearing the counter beats a simultaneous counter write.
// [R07] Word write to counter wins over a simultaneous increment.
// [R08] Byte write: written byte loads, other byte keeps old value, no increment.
// [R09] Running counter ticks at clock over 8, 32, 128 or 512, reset over 8.
// [R10] On match counter clears to zero, flag sets, counting resumes upward.
// [R11] Reset or standby: period all ones, everything else zero.
// [R12] Writing one to the flag does nothing; channels identical and independent.
// [R13] The APB access edge is the single cycle committing write data.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mtu_top
  import mtu_pkg::*;
#(
  parameter int NUM_CH = NCH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [NUM_CH-1:0] xfer_clr,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_CH-1:0] match_irq_request
);
  if (NUM_CH < 1 || NUM_CH > NCH) begin : g_bad_ch
    $error("NUM_CH out of range for register map");
  end

  logic [PRESC_W-1:0] presc_r;
  logic [NUM_CH-1:0] run_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic [NUM_CH-1:0] ch_hit;
  logic [31:0] ch_word [NUM_CH];
  logic [31:0] rd_word;
  mtu_chan_t regs [NUM_CH];

  wire [5:0] idx = paddr[7:2];
  wire setup = psel & ~penable;
  wire commit = psel & penable & pready_r; // R13
  wire run_hit = (idx == IDX_RUN);
  wire mapped = run_hit | (|ch_hit);

  // One shared divider keeps the channel ticks phase-aligned
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      presc_r <= '0;
    end else begin
      presc_r <= standby ? '0 : presc_r + 9'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_r <= '0;
    end else if (standby) begin
      run_r <= '0; // R11
    end else if (commit && pwrite && run_hit && pstrb[0]) begin
      run_r <= pwdata[NUM_CH-1:0];
    end
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam logic [5:0] BASE = 6'(IDX_CH0 + IDX_STRIDE * i);
    logic [PRESC_W-1:0] mask;
    mtu_acc_t acc;
    wire csr_hit = (idx == BASE + SUB_CSR);
    wire cnt_hit = (idx == BASE + SUB_CNT);
    wire per_hit = (idx == BASE + SUB_PER);
    assign mask = (regs[i].cks == 2'h0) ? DIV8_MASK :
                  (regs[i].cks == 2'h1) ? DIV32_MASK :
                  (regs[i].cks == 2'h2) ? DIV128_MASK : DIV512_MASK; // R09
    wire tick = run_r[i] & ((presc_r & mask) == mask); // R09
    assign ch_hit[i] = csr_hit | cnt_hit | per_hit;
    assign acc = '{wr_csr: commit & pwrite & csr_hit,
                   wr_cnt: commit & pwrite & cnt_hit & (|pstrb[1:0]),
                   wr_per: commit & pwrite & per_hit & (|pstrb[1:0]),
                   rd_csr: commit & ~pwrite & csr_hit,
                   strb: pstrb[1:0],
                   wdata: pwdata[15:0]}; // R13
    assign ch_word[i] = csr_hit ? {24'h000000, regs[i].flag, regs[i].ie, 4'h0, regs[i].cks} :
                        cnt_hit ? {16'h0000, regs[i].cnt} :
                        per_hit ? {16'h0000, regs[i].per} : 32'h00000000;
    mtu_channel u_ch (
      .clk(clk),
      .rst_b(rst_b),
      .standby(standby),
      .tick(tick),
      .xfer_clr(xfer_clr[i]),
      .acc(acc),
      .regs(regs[i]),
      .irq(match_irq_request[i]) // R01
    );
    a_tick_div: assert property (@(posedge clk) disable iff (!rst_b)
      tick |-> run_r[i] && presc_r[2:0] == 3'h7) else $error("tick off divider"); // R09
    a_stop_holds: assert property (@(posedge clk) disable iff (!rst_b)
      !run_r[i] && !acc.wr_cnt && !standby |=> regs[i].cnt == $past(regs[i].cnt))
      else $error("stopped counter moved"); // R09
  end

  always_comb begin
    rd_word = run_hit ? {{(32 - NUM_CH){1'b0}}, run_r} : 32'h00000000;
    for (int i = 0; i < NUM_CH; i++) begin
      rd_word = rd_word | ch_word[i];
    end
  end

  // Zero-wait: pready rises for the cycle after setup only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata_r <= rd_word;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  a_ready_once: assert property (@(posedge clk) disable iff (!rst_b)
    setup |=> pready_r ##1 !pready_r) else $error("pready not one cycle after setup");
  a_standby_init: assert property (@(posedge clk) disable iff (!rst_b)
    standby |=> run_r == '0 && regs[0].per == PER_RST && regs[0].cnt == CNT_RST
    && !regs[0].flag) else $error("standby did not initialise"); // R11
endmodule : mtu_top
`default_nettype wire

// [mtu_xfer_model.sv]
// Purpose: transfer controller stand-in for the match timer unit
// Assumes: one clear strobe per channel
// Notes: clears a raised request only while the bench commands it
`timescale 1ns/1ps
`default_nettype none
module mtu_xfer_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] go,
  input wire logic [1:0] irq,
  output logic [1:0] xfer_clr
);
  // One-cycle strobe, never held, so no double clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) xfer_clr <= 2'h0;
    else xfer_clr <= go & irq & ~xfer_clr;
  end
endmodule : mtu_xfer_model
`default_nettype wire

// [mtu_tb.sv]
// Purpose: self-checking bench for the match timer unit
// Assumes: zero-wait slave, channel 0 exercised, channel 1 watched
// Notes: byte lanes kept at the low half word
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mtu_pkg::*;
  logic clk, rst_b, standby, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [1:0] irq, xclr, go;
  int error_cnt, cmp_count, n;
  mtu_top dut_u (.clk(clk), .rst_b(rst_b), .standby(standby), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .xfer_clr(xclr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .match_irq_request(irq));
  mtu_xfer_model far_u (.clk(clk), .rst_b(rst_b), .go(go), .irq(irq),
    .xfer_clr(xclr));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    // Look between edges: outputs launched on an edge race a same-step read
    do begin
      @(negedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16) chk(32'h0, 32'h1);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdck(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdck
  task irqck(input logic [1:0] e);
    @(negedge clk);
    chk({30'h0, irq}, {30'h0, e});
  endtask : irqck
  task rise(output int c);
    c = 0;
    while (irq[0] !== 1'b0 && c < 3000) begin
      @(negedge clk);
      c++;
    end
    while (irq[0] !== 1'b1 && c < 3000) begin
      @(negedge clk);
      c++;
    end
  endtask : rise
  task t_reset;
    rdck(8'h0C, 32'h0000FFFF);
    rdck(8'h08, 32'h0);
    rdck(8'h04, 32'h0);
    rdck(8'h00, 32'h0);
  endtask : t_reset
  task t_match;
    wr(8'h0C, 32'h3);
    wr(8'h04, 32'h40);
    wr(8'h00, 32'h1);
    rise(n);
    rdck(8'h08, 32'h0);
    irqck(2'h1);
    rdck(8'h04, 32'hC0);
    rdck(8'h18, 32'h0000FFFF);
  endtask : t_match
  task t_clear;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'hC0);
    wr(8'h04, 32'h40);
    irqck(2'h1);
    rdck(8'h04, 32'hC0);
    wr(8'h04, 32'h40);
    irqck(2'h0);
    rdck(8'h04, 32'h40);
  endtask : t_clear
  task t_rate;
    go <= 2'h1;
    wr(8'h00, 32'h1);
    // Second interval only: the first spans the tick change
    for (int s = 0; s < 4; s++) begin
      wr(8'h04, 32'h40 | s);
      rise(n);
      rise(n);
      chk(n, 32'd32 << (2 * s));
    end
    wr(8'h00, 32'h0);
    go <= 2'h0;
    irqck(2'h0);
  endtask : t_rate
  task t_standby;
    wr(8'h18, 32'h1234);
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    rdck(8'h18, 32'h0000FFFF);
    rdck(8'h04, 32'h0);
  endtask : t_standby
  task t_unmapped;
    rdck(8'h1C, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask : t_unmapped
  task print_verdict;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    {rst_b, standby, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'h3;
    go = 2'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_match();
    t_clear();
    t_rate();
    t_standby();
    t_unmapped();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
